// file: pvwd_window_decode.sv
// Purpose: PCI to VME window decode and translation, windows 4 to 6
// Assumes: Request comes from logic on mclk; registers over classic Wishbone
// Notes:   Lowest numbered claiming window wins; result one cycle after request
//
// Operation
// - Claim only when address is at or above base and below bound.
// - A zero bound means no upper limit above the base.
// - Window 4 compares bits 31:12; windows 5 and 6 compare bits 31:16.
// - Window 4 VME address bits 31:12 are PCI bits plus offset.
// - Coarse windows form VME bits 31:16 as PCI bits plus offset.
// - Each window has an enable bit, reset to 0, gating all decode.
// - I/O-space windows ignore posted-write enable; transfers stay coupled.
// - Width field: 00 8, 01 16, 10 32, 11 64 bits; reset 10.
// - Space field: A16, A24, A32, two reserved, CR/CSR, user1, user2; reset 0.
// - Program bit: 0 data cycles, 1 program cycles; reset 0.
// - Supervisor bit: 0 non-privileged, 1 supervisor; reset 0.
// - Block bit works only in A24/A32 with width 8, 16 or 32.
// - A24/A32 with 64-bit width may use MBLT regardless of block bit.
// - PCI space bit: 0 memory, 1 I/O; reset 0.
// - Base, bound and offset are read/write and reset to zero.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps

module pvwd_window_decode (
   // Clock, reset and enable
   input  wire logic                mclk,
   input  wire logic                reset,
   input  wire logic                clk_en,
   // Wishbone slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [11:0]         wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic      [31:0]         wb_dat_o,
   output logic                     wb_ack_o,
   // PCI access to decode
   input  wire pvwd_pkg::pvwd_req_s pci_req,
   // Decode result
   output pvwd_pkg::pvwd_res_s      vme_res
);

   // Register state
   logic [31:0]          ctl_q   [pvwd_pkg::NWIN];
   logic [31:0]          ctl_d   [pvwd_pkg::NWIN];
   logic [31:0]          base_q  [pvwd_pkg::NWIN];
   logic [31:0]          base_d  [pvwd_pkg::NWIN];
   logic [31:0]          limit_q [pvwd_pkg::NWIN];
   logic [31:0]          limit_d [pvwd_pkg::NWIN];
   logic [31:0]          shift_q [pvwd_pkg::NWIN];
   logic [31:0]          shift_d [pvwd_pkg::NWIN];
   pvwd_pkg::pvwd_bus_e  bus_q;
   pvwd_pkg::pvwd_bus_e  bus_d;
   logic [31:0]          rdat_q;
   logic [31:0]          rdat_d;
   pvwd_pkg::pvwd_res_s  res_q;
   pvwd_pkg::pvwd_res_s  res_d;
   pvwd_pkg::pvwd_res_s  last_q;
   pvwd_pkg::pvwd_res_s  last_d;
   pvwd_pkg::pvwd_regsel_s rsel;

   // Compare granularity of a window
   function automatic logic [31:0] win_mask(input int i);
      win_mask = (i == 0) ? pvwd_pkg::FINE_MASK
                          : pvwd_pkg::COARSE_MASK;
   endfunction

   // Byte-lane merge of a write into a register
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel,
                                              input logic [31:0] mask);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      lane_merge = r & mask;
   endfunction

   // Register address decode
   function automatic pvwd_pkg::pvwd_regsel_s reg_lookup(input logic [11:0] a);
      pvwd_pkg::pvwd_regsel_s s;
      s = '{hit: 1'b1, idx: 2'h0, kind: pvwd_pkg::K_CTL};
      case (a)
         pvwd_pkg::OFF_W4_CTL:   s = '{1'b1, 2'h0, pvwd_pkg::K_CTL};
         pvwd_pkg::OFF_W4_BASE:  s = '{1'b1, 2'h0, pvwd_pkg::K_BASE};
         pvwd_pkg::OFF_W4_LIMIT: s = '{1'b1, 2'h0, pvwd_pkg::K_LIMIT};
         pvwd_pkg::OFF_W4_SHIFT: s = '{1'b1, 2'h0, pvwd_pkg::K_SHIFT};
         pvwd_pkg::OFF_W5_CTL:   s = '{1'b1, 2'h1, pvwd_pkg::K_CTL};
         pvwd_pkg::OFF_W5_BASE:  s = '{1'b1, 2'h1, pvwd_pkg::K_BASE};
         pvwd_pkg::OFF_W5_LIMIT: s = '{1'b1, 2'h1, pvwd_pkg::K_LIMIT};
         pvwd_pkg::OFF_W5_SHIFT: s = '{1'b1, 2'h1, pvwd_pkg::K_SHIFT};
         pvwd_pkg::OFF_W6_CTL:   s = '{1'b1, 2'h2, pvwd_pkg::K_CTL};
         pvwd_pkg::OFF_W6_BASE:  s = '{1'b1, 2'h2, pvwd_pkg::K_BASE};
         pvwd_pkg::OFF_W6_LIMIT: s = '{1'b1, 2'h2, pvwd_pkg::K_LIMIT};
         pvwd_pkg::OFF_W6_SHIFT: s = '{1'b1, 2'h2, pvwd_pkg::K_SHIFT};
         default:                s = '{1'b0, 2'h0, pvwd_pkg::K_CTL};
      endcase
      reg_lookup = s;
   endfunction

   // Space is A24 or A32
   function automatic logic wide_space(input logic [2:0] vme_space_select);
      wide_space = (vme_space_select == pvwd_pkg::SP_A24) || (vme_space_select == pvwd_pkg::SP_A32);
   endfunction

   assign rsel = reg_lookup(wb_adr_i);

   // Wishbone slave: answer one cycle after the request, write at the ack edge
   always_comb begin
      bus_d  = bus_q;
      rdat_d = rdat_q;
      for (int i = 0; i < pvwd_pkg::NWIN; i++) begin
         ctl_d[i]   = ctl_q[i];
         base_d[i]  = base_q[i];
         limit_d[i] = limit_q[i];
         shift_d[i] = shift_q[i];
      end
      case (bus_q)
         pvwd_pkg::BUS_IDLE: begin
            if (wb_cyc_i && wb_stb_i) begin
               bus_d  = pvwd_pkg::BUS_ACK;
               rdat_d = pvwd_pkg::ZERO_WORD;
               if (rsel.hit) begin
                  case (rsel.kind)
                     pvwd_pkg::K_CTL:   rdat_d = ctl_q[rsel.idx];
                     pvwd_pkg::K_BASE:  rdat_d = base_q[rsel.idx];
                     pvwd_pkg::K_LIMIT: rdat_d = limit_q[rsel.idx];
                     pvwd_pkg::K_SHIFT: rdat_d = shift_q[rsel.idx];
                     default:           rdat_d = pvwd_pkg::ZERO_WORD;
                  endcase
               end else if (wb_adr_i == pvwd_pkg::OFF_STATUS) begin
                  rdat_d[pvwd_pkg::STAT_CLAIM] = last_q.claim;
                  rdat_d[pvwd_pkg::STAT_WIN_HI:pvwd_pkg::STAT_WIN_LO] = last_q.image;
                  rdat_d[pvwd_pkg::STAT_POSTED] = last_q.posted;
               end
            end
         end
         pvwd_pkg::BUS_ACK: begin
            bus_d = pvwd_pkg::BUS_IDLE;
            if (wb_cyc_i && wb_stb_i && wb_we_i && rsel.hit) begin
               case (rsel.kind)
                  pvwd_pkg::K_CTL: begin
                     ctl_d[rsel.idx] = lane_merge(ctl_q[rsel.idx], wb_dat_i, wb_sel_i,
                                                  pvwd_pkg::CTL_MASK);
                  end
                  pvwd_pkg::K_BASE: begin
                     base_d[rsel.idx] = lane_merge(base_q[rsel.idx], wb_dat_i, wb_sel_i,
                                                   win_mask(int'(rsel.idx)));
                  end
                  pvwd_pkg::K_LIMIT: begin
                     limit_d[rsel.idx] = lane_merge(limit_q[rsel.idx], wb_dat_i, wb_sel_i,
                                                    win_mask(int'(rsel.idx)));
                  end
                  pvwd_pkg::K_SHIFT: begin
                     shift_d[rsel.idx] = lane_merge(shift_q[rsel.idx], wb_dat_i, wb_sel_i,
                                                    win_mask(int'(rsel.idx)));
                  end
                  default: begin
                     ctl_d[rsel.idx] = ctl_q[rsel.idx];
                  end
               endcase
            end
         end
         default: begin
            bus_d = pvwd_pkg::BUS_IDLE;
         end
      endcase
   end

   // Window decode and translation
   always_comb begin
      logic        found;
      logic        in_range;
      logic [31:0] m;
      logic [31:0] a;
      logic [2:0]  vme_space_select;
      logic [1:0]  max_vme_width;
      found    = 1'b0;
      in_range = 1'b0;
      m        = pvwd_pkg::COARSE_MASK;
      a        = pvwd_pkg::ZERO_WORD;
      vme_space_select      = pvwd_pkg::SP_A16;
      max_vme_width      = pvwd_pkg::W32;
      res_d       = '0;
      res_d.valid = pci_req.valid;
      res_d.space = pvwd_pkg::SP_A16;
      res_d.width = pvwd_pkg::W32;
      if (pci_req.valid) begin
         for (int i = 0; i < pvwd_pkg::NWIN; i++) begin
            m = win_mask(i);
            a = pci_req.addr & m;
            in_range = (a >= base_q[i])
                       && ((limit_q[i] == pvwd_pkg::ZERO_WORD)
                           || (a < limit_q[i]));
            if (!found && ctl_q[i][pvwd_pkg::CTL_EN]
                && (ctl_q[i][pvwd_pkg::CTL_LAS] == pci_req.is_io)
                && in_range) begin
               found = 1'b1;
               vme_space_select   = ctl_q[i][pvwd_pkg::CTL_VAS_HI:pvwd_pkg::CTL_VAS_LO];
               max_vme_width   = ctl_q[i][pvwd_pkg::CTL_VDW_HI:pvwd_pkg::CTL_VDW_LO];
               res_d.claim    = 1'b1;
               res_d.image    = pvwd_pkg::FIRST_IMAGE + 3'(i);
               res_d.vme_addr = ((a + shift_q[i]) & m)
                                | (pci_req.addr & ~m);
               res_d.space    = pvwd_pkg::pvwd_space_e'(vme_space_select);
               res_d.width    = pvwd_pkg::pvwd_width_e'(max_vme_width);
               res_d.program_code_bit = ctl_q[i][pvwd_pkg::CTL_PGM];
               res_d.supervisor = ctl_q[i][pvwd_pkg::CTL_SUPER];
               res_d.block_xfer = ctl_q[i][pvwd_pkg::CTL_VCT] && wide_space(vme_space_select)
                                  && (max_vme_width != pvwd_pkg::W64);
               res_d.mblt     = wide_space(vme_space_select) && (max_vme_width == pvwd_pkg::W64);
               res_d.posted   = ctl_q[i][pvwd_pkg::CTL_POSTED_WRITE_ALLOW] && pci_req.is_write
                                && !ctl_q[i][pvwd_pkg::CTL_LAS];
            end
         end
      end
      last_d = last_q;
      if (res_q.valid) begin
         last_d = res_q;
      end
   end

   // State registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         bus_q  <= pvwd_pkg::BUS_IDLE;
         rdat_q <= pvwd_pkg::ZERO_WORD;
         res_q  <= '0;
         last_q <= '0;
         for (int i = 0; i < pvwd_pkg::NWIN; i++) begin
            ctl_q[i]   <= pvwd_pkg::CTL_RESET;
            base_q[i]  <= pvwd_pkg::ADDR_RESET;
            limit_q[i] <= pvwd_pkg::ADDR_RESET;
            shift_q[i] <= pvwd_pkg::ADDR_RESET;
         end
      end else if (clk_en) begin
         bus_q  <= bus_d;
         rdat_q <= rdat_d;
         res_q  <= res_d;
         last_q <= last_d;
         for (int i = 0; i < pvwd_pkg::NWIN; i++) begin
            ctl_q[i]   <= ctl_d[i];
            base_q[i]  <= base_d[i];
            limit_q[i] <= limit_d[i];
            shift_q[i] <= shift_d[i];
         end
      end
   end

   assign wb_ack_o = (bus_q == pvwd_pkg::BUS_ACK);
   assign wb_dat_o = rdat_q;
   assign vme_res  = res_q;

endmodule // pvwd_window_decode

// file: pvwd_pkg.sv
// Purpose: Shared constants, types and register map of the PCI to VME window decoder
// Assumes: Word-aligned byte offsets on a 12-bit Wishbone byte address
// Notes:   Window 4 uses 4 Kbyte granularity, windows 5 and 6 use 64 Kbyte
package pvwd_pkg;

   // Register byte offsets
   localparam logic [11:0] OFF_W4_CTL   = 12'h1A0;
   localparam logic [11:0] OFF_W4_BASE  = 12'h1A4;
   localparam logic [11:0] OFF_W4_LIMIT = 12'h1A8;
   localparam logic [11:0] OFF_W4_SHIFT = 12'h1B0;
   localparam logic [11:0] OFF_W5_CTL   = 12'h1B4;
   localparam logic [11:0] OFF_W5_BASE  = 12'h1B8;
   localparam logic [11:0] OFF_W5_LIMIT = 12'h1BC;
   localparam logic [11:0] OFF_W5_SHIFT = 12'h1C0;
   localparam logic [11:0] OFF_W6_CTL   = 12'h1C8;
   localparam logic [11:0] OFF_W6_BASE  = 12'h1CC;
   localparam logic [11:0] OFF_W6_LIMIT = 12'h1D0;
   localparam logic [11:0] OFF_W6_SHIFT = 12'h1D4;
   localparam logic [11:0] OFF_STATUS   = 12'h1F0;

   // Window count and numbering
   localparam int          NWIN        = 3;
   localparam logic [2:0]  FIRST_IMAGE = 3'h4;

   // Control word field positions
   localparam int CTL_EN     = 31;
   localparam int CTL_POSTED_WRITE_ALLOW   = 30;
   localparam int CTL_VDW_HI = 23;
   localparam int CTL_VDW_LO = 22;
   localparam int CTL_VAS_HI = 18;
   localparam int CTL_VAS_LO = 16;
   localparam int CTL_PGM    = 14;
   localparam int CTL_SUPER  = 12;
   localparam int CTL_VCT    = 8;
   localparam int CTL_LAS    = 0;

   // Reset values and writable masks
   localparam logic [31:0] CTL_RESET   = 32'h0080_0000;
   localparam logic [31:0] CTL_MASK    = 32'hC0C7_5101;
   localparam logic [31:0] ADDR_RESET  = 32'h0000_0000;
   localparam logic [31:0] FINE_MASK   = 32'hFFFF_F000;
   localparam logic [31:0] COARSE_MASK = 32'hFFFF_0000;
   localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

   // Status word field positions
   localparam int STAT_CLAIM  = 0;
   localparam int STAT_WIN_LO = 1;
   localparam int STAT_WIN_HI = 3;
   localparam int STAT_POSTED = 4;

   // Maximum VME data width codes
   typedef enum logic [1:0] {
      W8  = 2'h0,
      W16 = 2'h1,
      W32 = 2'h2,
      W64 = 2'h3
   } pvwd_width_e;

   // VME address space codes
   typedef enum logic [2:0] {
      SP_A16   = 3'h0,
      SP_A24   = 3'h1,
      SP_A32   = 3'h2,
      SP_RSV3  = 3'h3,
      SP_RSV4  = 3'h4,
      SP_CRCSR = 3'h5,
      SP_USER1 = 3'h6,
      SP_USER2 = 3'h7
   } pvwd_space_e;

   // Register kinds inside a window
   typedef enum logic [1:0] {
      K_CTL   = 2'h0,
      K_BASE  = 2'h1,
      K_LIMIT = 2'h2,
      K_SHIFT = 2'h3
   } pvwd_kind_e;

   // Bus slave states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_ACK  = 2'h1
   } pvwd_bus_e;

   // Register selection
   typedef struct packed {
      logic       hit;
      logic [1:0] idx;
      pvwd_kind_e kind;
   } pvwd_regsel_s;

   // PCI access presented for decode
   typedef struct packed {
      logic        valid;
      logic        is_io;
      logic        is_write;
      logic [31:0] addr;
   } pvwd_req_s;

   // Decode result toward the VME master
   typedef struct packed {
      logic        valid;
      logic        claim;
      logic [2:0]  image;
      logic [31:0] vme_addr;
      pvwd_space_e space;
      pvwd_width_e width;
      logic        program_code_bit;
      logic        supervisor;
      logic        block_xfer;
      logic        mblt;
      logic        posted;
   } pvwd_res_s;

endpackage

// file: pvwd_window_decode_assertions.sv
// Purpose: Port checks of the window decoder
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the decoder after the module
`timescale 1ns/10ps
module pvwd_window_decode_assertions (
   // Clock and reset
   input logic                mclk,
   input logic                reset,
   input logic                clk_en,
   // Wishbone
   input logic                wb_cyc_i,
   input logic                wb_stb_i,
   input logic                wb_we_i,
   input logic [11:0]         wb_adr_i,
   input logic [3:0]          wb_sel_i,
   input logic [31:0]         wb_dat_i,
   input logic [31:0]         wb_dat_o,
   input logic                wb_ack_o,
   // Decode port
   input pvwd_pkg::pvwd_req_s pci_req,
   input pvwd_pkg::pvwd_res_s vme_res
);
   logic ctl_hit;
   logic en_d;
   logic en_q;
   // Set once an enable bit is written into a control word
   always_comb begin
      ctl_hit = wb_adr_i == pvwd_pkg::OFF_W4_CTL || wb_adr_i == pvwd_pkg::OFF_W5_CTL
                || wb_adr_i == pvwd_pkg::OFF_W6_CTL;
      en_d = reset ? 1'b0 : en_q | (wb_ack_o & wb_we_i & wb_sel_i[3] & wb_dat_i[31] & ctl_hit);
   end
   always_ff @(posedge mclk) begin
      en_q <= en_d;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   property p_ack_once; wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
   property p_res_valid; clk_en |=> vme_res.valid == $past(pci_req.valid); endproperty
   a_res_valid: assert property (p_res_valid) else $error("result strobe wrong");
   property p_claim_img; vme_res.valid |-> vme_res.claim == (vme_res.image inside {[3'h4:3'h6]});
   endproperty
   a_claim_img: assert property (p_claim_img) else $error("claim and window disagree");
   property p_off_quiet; !en_q |-> !vme_res.claim; endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("claim while all windows off");
   property p_io_coupled; pci_req.valid && clk_en && pci_req.is_io |=> !vme_res.posted;
   endproperty
   a_io_coupled: assert property (p_io_coupled) else $error("I/O access posted");
   property p_blt; vme_res.block_xfer |-> vme_res.space inside {pvwd_pkg::SP_A24, pvwd_pkg::SP_A32}
      && vme_res.width != pvwd_pkg::W64; endproperty
   a_blt: assert property (p_blt) else $error("block transfer out of place");
   property p_mblt; vme_res.claim |-> vme_res.mblt == (vme_res.width == pvwd_pkg::W64
      && vme_res.space inside {pvwd_pkg::SP_A24, pvwd_pkg::SP_A32}); endproperty
   a_mblt: assert property (p_mblt) else $error("wide block choice wrong");
   property p_fine_low; pci_req.valid && clk_en ##1 vme_res.claim && vme_res.image == 3'h4
      |-> vme_res.vme_addr[11:0] == $past(pci_req.addr[11:0]); endproperty
   a_fine_low: assert property (p_fine_low) else $error("fine window low bits changed");
   property p_coarse_low; pci_req.valid && clk_en ##1 vme_res.claim && vme_res.image != 3'h4
      |-> vme_res.vme_addr[15:0] == $past(pci_req.addr[15:0]); endproperty
   a_coarse_low: assert property (p_coarse_low) else $error("coarse low bits changed");
   c_fine: cover property (vme_res.claim && vme_res.image == 3'h4);
   c_mblt: cover property (vme_res.mblt);
   c_blt: cover property (vme_res.block_xfer);
endmodule // pvwd_window_decode_assertions

bind pvwd_window_decode pvwd_window_decode_assertions u_chk (
   .mclk(mclk), .reset(reset), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pci_req(pci_req), .vme_res(vme_res));

// file: pvwd_pci_model.sv
// Purpose: PCI initiator and VME master stand-in for the decoder
// Assumes: Same clock as the decoder
// Notes:   Idle cycles before a request model a slow initiator
`timescale 1ns/10ps
module pvwd_pci_model (
   // Clock
   input  logic                mclk,
   // Request and result
   output pvwd_pkg::pvwd_req_s pci_req,
   input  pvwd_pkg::pvwd_res_s vme_res
);
   pvwd_pkg::pvwd_res_s seen;
   initial pci_req = {1'b0, 1'b0, 1'b0, 32'h0000_0000};
   task automatic issue(input logic [31:0] a, input logic io, input logic wr, input int idle);
      repeat (idle) @(posedge mclk);
      @(posedge mclk);
      pci_req <= {1'b1, io, wr, a};
      @(posedge mclk);
      // Released lines show inverted values, never the stale request
      pci_req <= {1'b0, ~io, ~wr, ~a};
      #1;
      seen = vme_res;
   endtask
endmodule // pvwd_pci_model

// file: tb_top.sv
// Purpose: Register and decode tests of the window decoder
// Assumes: 40 MHz clock, clock enable held high
// Notes:   Expected results are built from the field layout
`timescale 1ns/10ps
module tb_top;
   logic                mclk = 1'b0;
   logic                reset = 1'b1;
   logic                clk_en = 1'b1;
   logic                wb_cyc_i = 1'b0;
   logic                wb_stb_i = 1'b0;
   logic                wb_we_i = 1'b0;
   logic [11:0]         wb_adr_i = 12'h000;
   logic [3:0]          wb_sel_i = 4'h0;
   logic [31:0]         wb_dat_i = 32'h0000_0000;
   logic [31:0]         wb_dat_o;
   logic                wb_ack_o;
   logic [31:0]         q;
   logic                bl;
   logic                mb;
   pvwd_pkg::pvwd_req_s pci_req;
   pvwd_pkg::pvwd_res_s vme_res;
   pvwd_pkg::pvwd_res_s nc;
   int                  fail_count = 0;
   int                  total_checks = 0;
   int                  cycles = 0;
   logic [11:0]         offs [12] = '{pvwd_pkg::OFF_W4_CTL, pvwd_pkg::OFF_W4_BASE,
      pvwd_pkg::OFF_W4_LIMIT, pvwd_pkg::OFF_W4_SHIFT, pvwd_pkg::OFF_W5_CTL, pvwd_pkg::OFF_W5_BASE,
      pvwd_pkg::OFF_W5_LIMIT, pvwd_pkg::OFF_W5_SHIFT, pvwd_pkg::OFF_W6_CTL, pvwd_pkg::OFF_W6_BASE,
      pvwd_pkg::OFF_W6_LIMIT, pvwd_pkg::OFF_W6_SHIFT};

   always #12.5 mclk = ~mclk;

   pvwd_window_decode dut (
      .mclk(mclk), .reset(reset), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pci_req(pci_req), .vme_res(vme_res));
   pvwd_pci_model u_pci (.mclk(mclk), .pci_req(pci_req), .vme_res(vme_res));

   task automatic results();
      if (fail_count == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         results();
      end
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic do_reset();
      reset <= 1'b1;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
   endtask

   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [11:0] a, input logic [3:0] s,
                     input logic [31:0] d, output logic [31:0] r);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      @(posedge mclk);
      while (wb_ack_o !== 1'b1) @(posedge mclk);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   function automatic logic [31:0] cw(input logic en, pw, input logic [1:0] w,
                                      input logic [2:0] sp, input logic pg, su, vc, ls);
      cw = {en, pw, 6'h00, w, 3'h0, sp, 1'h0, pg, 1'h0, su, 3'h0, vc, 7'h00, ls};
   endfunction

   function automatic pvwd_pkg::pvwd_res_s rs(input logic [2:0] img, input logic [31:0] va,
                                              input logic [2:0] sp, input logic [1:0] w,
                                              input logic [4:0] f);
      rs = {1'b1, img != 3'h0, img, va, sp, w, f};
   endfunction

   task automatic dec(input logic [31:0] a, input logic io, wr, input pvwd_pkg::pvwd_res_s e);
      u_pci.issue(a, io, wr, 0);
      chk(u_pci.seen, e);
   endtask

   initial begin
      nc = rs(3'h0, 32'h0000_0000, 3'h0, 2'h2, 5'h00);
      for (int p = 0; p < 2; p++) begin
         do_reset();
         for (int i = 0; i < 12; i++) begin
            wb(1'b0, offs[i], 4'hF, 32'h0000_0000, q);
            chk(q, (i % 4 == 0) ? pvwd_pkg::CTL_RESET : pvwd_pkg::ZERO_WORD);
            wb(1'b1, offs[i], 4'hF, 32'hFFFF_FFFF, q);
            wb(1'b0, offs[i], 4'hF, 32'h0000_0000, q);
            chk(q, (i % 4 == 0) ? pvwd_pkg::CTL_MASK : (i < 4) ? pvwd_pkg::FINE_MASK
                : pvwd_pkg::COARSE_MASK);
         end
      end
      do_reset();
      wb(1'b1, 12'h1C4, 4'hF, 32'hFFFF_FFFF, q);
      wb(1'b0, 12'h1C4, 4'hF, 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      wb(1'b1, pvwd_pkg::OFF_W5_BASE, 4'h8, 32'hA5A5_A5A5, q);
      wb(1'b0, pvwd_pkg::OFF_W5_BASE, 4'hF, 32'h0000_0000, q);
      chk(q, 32'hA500_0000);
      wb(1'b1, pvwd_pkg::OFF_W4_BASE, 4'hF, 32'h1000_3000, q);
      wb(1'b1, pvwd_pkg::OFF_W4_LIMIT, 4'hF, 32'h1000_5000, q);
      wb(1'b1, pvwd_pkg::OFF_W4_SHIFT, 4'hF, 32'h2000_1000, q);
      dec(32'h1000_3000, 1'b0, 1'b0, nc);
      wb(1'b1, pvwd_pkg::OFF_W4_CTL, 4'hF, cw(1'b1, 1'b0, 2'h2, 3'h2, 1'b1, 1'b1, 1'b0, 1'b0), q);
      dec(32'h1000_2FFC, 1'b0, 1'b0, nc);
      dec(32'h1000_3004, 1'b0, 1'b0, rs(3'h4, 32'h3000_4004, 3'h2, 2'h2, 5'h18));
      dec(32'h1000_4FFF, 1'b0, 1'b1, rs(3'h4, 32'h3000_5FFF, 3'h2, 2'h2, 5'h18));
      dec(32'h1000_5000, 1'b0, 1'b0, nc);
      dec(32'h1000_3004, 1'b1, 1'b0, nc);
      wb(1'b1, pvwd_pkg::OFF_W5_BASE, 4'hF, 32'h2000_0000, q);
      wb(1'b1, pvwd_pkg::OFF_W5_SHIFT, 4'hF, 32'hF000_0000, q);
      wb(1'b1, pvwd_pkg::OFF_W5_CTL, 4'hF, cw(1'b1, 1'b1, 2'h3, 3'h1, 1'b0, 1'b0, 1'b1, 1'b0), q);
      dec(32'hFFFF_1234, 1'b0, 1'b1, rs(3'h5, 32'hEFFF_1234, 3'h1, 2'h3, 5'h03));
      dec(32'h1FFF_FFFF, 1'b0, 1'b0, nc);
      dec(32'h2000_0000, 1'b0, 1'b0, rs(3'h5, 32'h1000_0000, 3'h1, 2'h3, 5'h02));
      wb(1'b1, pvwd_pkg::OFF_W6_BASE, 4'hF, 32'h4000_0000, q);
      wb(1'b1, pvwd_pkg::OFF_W6_LIMIT, 4'hF, 32'h4001_0000, q);
      for (int s = 0; s < 8; s++) begin
         for (int w = 0; w < 4; w++) begin
            wb(1'b1, pvwd_pkg::OFF_W6_CTL, 4'hF,
               cw(1'b1, 1'b1, 2'(w), 3'(s), 1'b0, 1'b0, 1'b1, 1'b1), q);
            bl = (s == 1 || s == 2) && w != 3;
            mb = (s == 1 || s == 2) && w == 3;
            dec(32'h4000_FFF0, 1'b1, 1'b1, rs(3'h6, 32'h4000_FFF0, 3'(s), 2'(w),
                {2'b00, bl, mb, 1'b0}));
         end
      end
      dec(32'h4001_0000, 1'b1, 1'b0, nc);
      dec(32'h4000_0000, 1'b0, 1'b1, rs(3'h5, 32'h3000_0000, 3'h1, 2'h3, 5'h03));
      wb(1'b1, pvwd_pkg::OFF_W5_CTL, 4'hF, 32'h0000_0000, q);
      dec(32'hFFFF_1234, 1'b0, 1'b0, nc);
      wb(1'b1, pvwd_pkg::OFF_W6_CTL, 4'hF, cw(1'b1, 1'b1, 2'h2, 3'h2, 1'b1, 1'b0, 1'b0, 1'b0), q);
      dec(32'h4000_0010, 1'b0, 1'b1, rs(3'h6, 32'h4000_0010, 3'h2, 2'h2, 5'h11));
      wb(1'b0, pvwd_pkg::OFF_STATUS, 4'hF, 32'h0000_0000, q);
      chk(q, 32'h0000_001D);
      dec(32'h4000_0010, 1'b1, 1'b1, nc);
      results();
   end
endmodule // tb_top
